// >>> hdl/jpe_consts.vh
// constants for the test-port claim and programming session block
`ifndef JPE_CONSTS_VH
`define JPE_CONSTS_VH

// control register space
`define JPE_ENABLE_OFFSET 8'hc7
`define JPE_ENABLE_BIT 0
`define JPE_ENABLE_RESET 1'b0
`define JPE_RDATA_RESET 8'h00

// port c pin positions
`define JPE_PIN_MODE 0
`define JPE_PIN_TCLK 1
`define JPE_PIN_STATUS 3
`define JPE_PIN_ERROR 4
`define JPE_PIN_DIN 5
`define JPE_PIN_DOUT 6
`define JPE_PIN_DEVRST 8

// synchroniser reset value: pins low, device reset released
`define JPE_SYNC_RESET 9'h100

// instruction register
`define JPE_IR_W 4
`define JPE_IR_CAPTURE 4'h1
`define JPE_IR_RESET 4'hf
`define JPE_INS_OPEN 4'h1
`define JPE_INS_OPEN_OD 4'h2
`define JPE_INS_CLOSE 4'h3
`define JPE_INS_CLEAR 4'h4
`define JPE_INS_PROGRAM 4'h5
`define JPE_INS_ERASE 4'h6
`define JPE_INS_CHIP_ERASE 4'h7
`define JPE_INS_READ 4'h8
`define JPE_INS_VERIFY 4'h9

// data register layout
`define JPE_DR_W 24
`define JPE_DR_RESET 24'h000000
`define JPE_DR_ADDR_LSB 0
`define JPE_DR_ADDR_MSB 15
`define JPE_DR_DATA_LSB 16
`define JPE_DR_DATA_MSB 23
`define JPE_DR_SECT_MSB 3

// memory operations
`define JPE_OP_NONE 3'h0
`define JPE_OP_PROGRAM 3'h1
`define JPE_OP_SECT_ERASE 3'h2
`define JPE_OP_CHIP_ERASE 3'h3
`define JPE_OP_READ 3'h4
`define JPE_OP_VERIFY 3'h5

// sector protect: 8 flash sectors then 4 eeprom sectors
`define JPE_NUM_SECT 12

`endif

// >>> hdl/jpe_port.v
// test-port pin claim, programming session and port c pin mux
//
// Overview of operation
// - mode, clock, data in and data out sit on port c pins 0,1,5,6.
// - four test pins claimed when nvm bit, enable bit or logic term is true.
// - unclaimed test pins fall back to general purpose i/o.
// - claimed pins stay inputs; data out drives only after the session open command.
// - enable register at offset c7h; bit 0 set claims the test pins.
// - device reset clears the enable bit; software may also clear it.
// - dedicated logic product term is the third pin-claim source.
// - a blank device claims the four test pins by default.
// - status and error pins enabled only by the session open command.
// - error pin low on flash failure until clear, or reset after close.
// - eeprom failures never reach the error pin.
// - status pin high in read mode, low while programming, erasing or writing.
// - session open may make status and error pins open drain.
// - security bit refuses reads and all memory commands except full chip erase.
// - full chip erase lifts the security protection.
// - per-sector protect bits block erasure of protected sectors.
// - device reset aborts port activity unless the nvm bit or a blank device claims the pins.
// - configuration commands supported; no boundary scan.
// - configuration and register bits start at zero except instruction registers (fh), state register (test-logic-reset), output enables (ffh), reset sync bit.
`timescale 1ns/1ps
`include "jpe_consts.vh"

module jpe_port (
   input wire CORE_CLK_I,
   input wire POR_N_I,
   input wire RST_N_I,
   input wire [7:0] REG_ADDR_I,
   input wire [7:0] REG_WDATA_I,
   input wire REG_WR_I,
   input wire REG_RD_I,
   output wire [7:0] REG_RDATA_O,
   input wire NVM_PORT_SEL_I,
   input wire DEVICE_BLANK_I,
   input wire LOGIC_PORT_CLAIM_TERM_I,
   input wire SECURITY_BIT_I,
   input wire [11:0] SECTOR_PROT_I,
   input wire [7:0] PORTC_I,
   output wire [7:0] PORTC_O,
   output wire [7:0] PORTC_OE_N_O,
   input wire [7:0] GPIO_OUT_I,
   input wire [7:0] GPIO_OE_N_I,
   output wire [7:0] GPIO_IN_O,
   input wire MEM_BUSY_I,
   input wire FLASH_ERR_I,
   input wire [7:0] MEM_RDATA_I,
   output wire MEM_REQ_O,
   output wire [2:0] MEM_OP_O,
   output wire [15:0] MEM_ADDR_O,
   output wire [7:0] MEM_WDATA_O,
   output wire [3:0] MEM_SECTOR_O,
   output wire SECURITY_CLEAR_O,
   output wire PORT_CLAIMED_O,
   output wire SESSION_OPEN_O
);

   localparam [15:0] ST_TLR = 16'h0001;
   localparam [15:0] ST_RTI = 16'h0002;
   localparam [15:0] ST_SDS = 16'h0004;
   localparam [15:0] ST_CDR = 16'h0008;
   localparam [15:0] ST_SHD = 16'h0010;
   localparam [15:0] ST_E1D = 16'h0020;
   localparam [15:0] ST_PDR = 16'h0040;
   localparam [15:0] ST_E2D = 16'h0080;
   localparam [15:0] ST_UDR = 16'h0100;
   localparam [15:0] ST_SIS = 16'h0200;
   localparam [15:0] ST_CIR = 16'h0400;
   localparam [15:0] ST_SHI = 16'h0800;
   localparam [15:0] ST_E1I = 16'h1000;
   localparam [15:0] ST_PIR = 16'h2000;
   localparam [15:0] ST_E2I = 16'h4000;
   localparam [15:0] ST_UIR = 16'h8000;

   ////////////////////////////////////////////////////////////////////////////////
   // functions

   function [15:0] tap_next;
      input [15:0] st;
      input tms;
      begin
         case (st)
            ST_TLR: tap_next = tms ? ST_TLR : ST_RTI;
            ST_RTI: tap_next = tms ? ST_SDS : ST_RTI;
            ST_SDS: tap_next = tms ? ST_SIS : ST_CDR;
            ST_CDR: tap_next = tms ? ST_E1D : ST_SHD;
            ST_SHD: tap_next = tms ? ST_E1D : ST_SHD;
            ST_E1D: tap_next = tms ? ST_UDR : ST_PDR;
            ST_PDR: tap_next = tms ? ST_E2D : ST_PDR;
            ST_E2D: tap_next = tms ? ST_UDR : ST_SHD;
            ST_UDR: tap_next = tms ? ST_SDS : ST_RTI;
            ST_SIS: tap_next = tms ? ST_TLR : ST_CIR;
            ST_CIR: tap_next = tms ? ST_E1I : ST_SHI;
            ST_SHI: tap_next = tms ? ST_E1I : ST_SHI;
            ST_E1I: tap_next = tms ? ST_UIR : ST_PIR;
            ST_PIR: tap_next = tms ? ST_E2I : ST_PIR;
            ST_E2I: tap_next = tms ? ST_UIR : ST_SHI;
            ST_UIR: tap_next = tms ? ST_SDS : ST_RTI;
            default: tap_next = ST_TLR;
         endcase
      end
   endfunction

   // unknown codes, boundary scan among them, fall to the one-bit bypass path
   function uses_data_reg;
      input [3:0] ins;
      begin
         uses_data_reg = (ins == `JPE_INS_PROGRAM) || (ins == `JPE_INS_ERASE) ||
                         (ins == `JPE_INS_READ) || (ins == `JPE_INS_VERIFY);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   reg [8:0] sync1_reg;
   reg [8:0] sync2_reg;
   reg [8:0] sync3_reg;
   reg [8:0] filt_reg;
   wire [8:0] filt_next;
   wire [8:0] disagree;

   assign disagree = sync2_reg ^ sync3_reg;
   // a change counts only when the second and third stages agree
   assign filt_next = (~disagree & sync3_reg) | (disagree & filt_reg);

   always @(posedge CORE_CLK_I or negedge POR_N_I) begin
      if (!POR_N_I) begin
         sync1_reg <= `JPE_SYNC_RESET;
         sync2_reg <= `JPE_SYNC_RESET;
         sync3_reg <= `JPE_SYNC_RESET;
         filt_reg <= `JPE_SYNC_RESET;
      end else begin
         sync1_reg <= {RST_N_I, PORTC_I};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         filt_reg <= filt_next;
      end
   end

   wire tck_rise;
   wire tck_fall;
   wire tms_s;
   wire tdi_s;
   wire dev_rst;

   assign tck_rise = filt_next[`JPE_PIN_TCLK] & ~filt_reg[`JPE_PIN_TCLK];
   assign tck_fall = ~filt_next[`JPE_PIN_TCLK] & filt_reg[`JPE_PIN_TCLK];
   assign tms_s = filt_next[`JPE_PIN_MODE];
   assign tdi_s = filt_next[`JPE_PIN_DIN];
   assign dev_rst = ~filt_reg[`JPE_PIN_DEVRST];

   ////////////////////////////////////////////////////////////////////////////////
   // enable register

   reg enable_reg;
   reg [7:0] rdata_reg;
   wire hit_enable;

   assign hit_enable = (REG_ADDR_I == `JPE_ENABLE_OFFSET);

   always @(posedge CORE_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         enable_reg <= `JPE_ENABLE_RESET;
         rdata_reg <= `JPE_RDATA_RESET;
      end else begin
         if (REG_WR_I && hit_enable)
            enable_reg <= REG_WDATA_I[`JPE_ENABLE_BIT];
         if (REG_RD_I && hit_enable)
            rdata_reg <= {7'h00, enable_reg};
         else
            rdata_reg <= `JPE_RDATA_RESET;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pin claim

   wire nvm_src;
   wire claim;
   wire tap_hold;

   assign nvm_src = NVM_PORT_SEL_I | DEVICE_BLANK_I;
   assign claim = nvm_src | enable_reg | LOGIC_PORT_CLAIM_TERM_I;
   assign tap_hold = ~claim | (dev_rst & ~nvm_src);

   ////////////////////////////////////////////////////////////////////////////////
   // test access state machine

   reg [15:0] tap_reg;
   reg [3:0] ir_reg;
   reg [3:0] ir_sh_reg;
   reg [23:0] dr_sh_reg;
   reg bypass_reg;
   reg tdo_reg;
   wire exec_ir;
   wire exec_dr;
   wire secure;
   wire dr_path;

   assign exec_ir = tck_rise & (tap_reg == ST_UIR) & ~tap_hold;
   assign exec_dr = tck_rise & (tap_reg == ST_UDR) & ~tap_hold;
   assign dr_path = uses_data_reg(ir_reg);

   always @(posedge CORE_CLK_I or negedge POR_N_I) begin
      if (!POR_N_I) begin
         tap_reg <= ST_TLR;
         ir_reg <= `JPE_IR_RESET;
         ir_sh_reg <= `JPE_IR_RESET;
         dr_sh_reg <= `JPE_DR_RESET;
         bypass_reg <= 1'b0;
         tdo_reg <= 1'b0;
      end else if (tap_hold) begin
         tap_reg <= ST_TLR;
         ir_reg <= `JPE_IR_RESET;
         ir_sh_reg <= `JPE_IR_RESET;
         bypass_reg <= 1'b0;
      end else begin
         if (tck_rise) begin
            tap_reg <= tap_next(tap_reg, tms_s);
            case (tap_reg)
               ST_TLR: ir_reg <= `JPE_IR_RESET;
               ST_CIR: ir_sh_reg <= `JPE_IR_CAPTURE;
               ST_SHI: ir_sh_reg <= {tdi_s, ir_sh_reg[3:1]};
               ST_UIR: ir_reg <= ir_sh_reg;
               ST_CDR: begin
                  bypass_reg <= 1'b0;
                  if ((ir_reg == `JPE_INS_READ || ir_reg == `JPE_INS_VERIFY) && !secure)
                     dr_sh_reg <= {MEM_RDATA_I, 16'h0000};
                  else
                     dr_sh_reg <= `JPE_DR_RESET;
               end
               ST_SHD: begin
                  if (dr_path)
                     dr_sh_reg <= {tdi_s, dr_sh_reg[23:1]};
                  else
                     bypass_reg <= tdi_s;
               end
               default: bypass_reg <= bypass_reg;
            endcase
         end
         if (tck_fall) begin
            if (tap_reg == ST_SHI)
               tdo_reg <= ir_sh_reg[0];
            else if (dr_path)
               tdo_reg <= dr_sh_reg[0];
            else
               tdo_reg <= bypass_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // session, error flag and memory commands

   reg open_reg;
   reg ext_en_reg;
   reg od_reg;
   reg closed_reg;
   reg err_reg;
   reg sec_clr_reg;
   reg sec_pulse_reg;
   reg mem_req_reg;
   reg [2:0] mem_op_reg;
   reg [15:0] mem_addr_reg;
   reg [7:0] mem_wdata_reg;
   reg [3:0] mem_sect_reg;
   wire [3:0] sect_idx;
   wire sect_ok;
   wire err_clear;
   wire cmd_ok;

   assign secure = SECURITY_BIT_I & ~sec_clr_reg;
   assign sect_idx = dr_sh_reg[`JPE_DR_SECT_MSB:0];
   assign sect_ok = (sect_idx < `JPE_NUM_SECT) && !SECTOR_PROT_I[sect_idx];
   assign err_clear = (exec_ir & open_reg & (ir_sh_reg == `JPE_INS_CLEAR)) |
                      (dev_rst & closed_reg);
   assign cmd_ok = exec_dr & open_reg & ~secure;

   always @(posedge CORE_CLK_I or negedge POR_N_I) begin
      if (!POR_N_I) begin
         open_reg <= 1'b0;
         ext_en_reg <= 1'b0;
         od_reg <= 1'b0;
         closed_reg <= 1'b0;
         err_reg <= 1'b0;
         sec_clr_reg <= 1'b0;
         sec_pulse_reg <= 1'b0;
         mem_req_reg <= 1'b0;
         mem_op_reg <= `JPE_OP_NONE;
         mem_addr_reg <= 16'h0000;
         mem_wdata_reg <= 8'h00;
         mem_sect_reg <= 4'h0;
      end else begin
         mem_req_reg <= 1'b0;
         sec_pulse_reg <= 1'b0;
         err_reg <= FLASH_ERR_I | (err_reg & ~err_clear);
         if (dev_rst && closed_reg) begin
            ext_en_reg <= 1'b0;
            closed_reg <= 1'b0;
         end
         if (tap_hold) begin
            open_reg <= 1'b0;
         end else if (exec_ir) begin
            case (ir_sh_reg)
               `JPE_INS_OPEN, `JPE_INS_OPEN_OD: begin
                  open_reg <= 1'b1;
                  ext_en_reg <= 1'b1;
                  od_reg <= (ir_sh_reg == `JPE_INS_OPEN_OD);
                  closed_reg <= 1'b0;
               end
               `JPE_INS_CLOSE: begin
                  if (open_reg) begin
                     open_reg <= 1'b0;
                     closed_reg <= 1'b1;
                  end
               end
               `JPE_INS_CHIP_ERASE: begin
                  if (open_reg) begin
                     mem_req_reg <= 1'b1;
                     mem_op_reg <= `JPE_OP_CHIP_ERASE;
                     sec_clr_reg <= 1'b1;
                     sec_pulse_reg <= 1'b1;
                  end
               end
               default: open_reg <= open_reg;
            endcase
         end else if (cmd_ok) begin
            mem_addr_reg <= dr_sh_reg[`JPE_DR_ADDR_MSB:`JPE_DR_ADDR_LSB];
            mem_wdata_reg <= dr_sh_reg[`JPE_DR_DATA_MSB:`JPE_DR_DATA_LSB];
            mem_sect_reg <= sect_idx;
            case (ir_reg)
               `JPE_INS_PROGRAM: begin
                  mem_req_reg <= 1'b1;
                  mem_op_reg <= `JPE_OP_PROGRAM;
               end
               `JPE_INS_ERASE: begin
                  mem_req_reg <= sect_ok;
                  mem_op_reg <= `JPE_OP_SECT_ERASE;
               end
               `JPE_INS_READ: begin
                  mem_req_reg <= 1'b1;
                  mem_op_reg <= `JPE_OP_READ;
               end
               `JPE_INS_VERIFY: begin
                  mem_req_reg <= 1'b1;
                  mem_op_reg <= `JPE_OP_VERIFY;
               end
               default: mem_req_reg <= 1'b0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // port c pin mux

   reg [7:0] pc_o_reg;
   reg [7:0] pc_oe_n_reg;
   reg claimed_reg;
   reg [7:0] pc_o_next;
   reg [7:0] pc_oe_n_next;
   reg ready;

   always @* begin
      ready = ~MEM_BUSY_I;
      pc_o_next = GPIO_OUT_I;
      pc_oe_n_next = GPIO_OE_N_I;
      if (claim) begin
         pc_oe_n_next[`JPE_PIN_MODE] = 1'b1;
         pc_oe_n_next[`JPE_PIN_TCLK] = 1'b1;
         pc_oe_n_next[`JPE_PIN_DIN] = 1'b1;
         pc_o_next[`JPE_PIN_DOUT] = tdo_reg;
         pc_oe_n_next[`JPE_PIN_DOUT] = ~(open_reg & ((tap_reg == ST_SHD) |
                                                     (tap_reg == ST_SHI)));
      end
      if (ext_en_reg) begin
         pc_o_next[`JPE_PIN_STATUS] = od_reg ? 1'b0 : ready;
         pc_oe_n_next[`JPE_PIN_STATUS] = od_reg ? ready : 1'b0;
         pc_o_next[`JPE_PIN_ERROR] = od_reg ? 1'b0 : ~err_reg;
         pc_oe_n_next[`JPE_PIN_ERROR] = od_reg ? ~err_reg : 1'b0;
      end
   end

   // one register stage on the pins; a cycle of lag is small against the test clock
   always @(posedge CORE_CLK_I or negedge POR_N_I) begin
      if (!POR_N_I) begin
         pc_o_reg <= 8'h00;
         pc_oe_n_reg <= 8'hff;
         claimed_reg <= 1'b0;
      end else begin
         pc_o_reg <= pc_o_next;
         pc_oe_n_reg <= pc_oe_n_next;
         claimed_reg <= claim;
      end
   end

   assign REG_RDATA_O = rdata_reg;
   assign PORTC_O = pc_o_reg;
   assign PORTC_OE_N_O = pc_oe_n_reg;
   assign GPIO_IN_O = filt_reg[7:0];
   assign MEM_REQ_O = mem_req_reg;
   assign MEM_OP_O = mem_op_reg;
   assign MEM_ADDR_O = mem_addr_reg;
   assign MEM_WDATA_O = mem_wdata_reg;
   assign MEM_SECTOR_O = mem_sect_reg;
   assign SECURITY_CLEAR_O = sec_pulse_reg;
   assign PORT_CLAIMED_O = claimed_reg;
   assign SESSION_OPEN_O = open_reg;

endmodule // jpe_port

// >>> testbench/jpe_port_checker.sv
// assertion checker for the test-port claim block
`timescale 1ns/1ps
module jpe_port_checker (
   input wire CORE_CLK_I,
   input wire POR_N_I,
   input wire RST_N_I,
   input wire REG_RD_I,
   input wire [7:0] REG_RDATA_O,
   input wire NVM_PORT_SEL_I,
   input wire DEVICE_BLANK_I,
   input wire LOGIC_PORT_CLAIM_TERM_I,
   input wire SECURITY_BIT_I,
   input wire [11:0] SECTOR_PROT_I,
   input wire [7:0] PORTC_O,
   input wire [7:0] PORTC_OE_N_O,
   input wire [7:0] GPIO_OE_N_I,
   input wire MEM_BUSY_I,
   input wire MEM_REQ_O,
   input wire [2:0] MEM_OP_O,
   input wire [3:0] MEM_SECTOR_O,
   input wire SECURITY_CLEAR_O,
   input wire PORT_CLAIMED_O,
   input wire SESSION_OPEN_O
);
   reg unsec_reg;
   ////////////////////////////////////////////////////////////////
   // chip erase lifts security until power-on reset
   always @(posedge CORE_CLK_I or negedge POR_N_I) begin
      if (!POR_N_I) unsec_reg <= 1'b0;
      else if (SECURITY_CLEAR_O) unsec_reg <= 1'b1;
   end
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!POR_N_I);
   ////////////////////////////////////////////////////////////////
   // released pins follow gpio; pins 3,4 skipped, they outlive a close
   property p_gpio;
      $past(POR_N_I, 2) && !PORT_CLAIMED_O && $past(!PORT_CLAIMED_O) && $stable(GPIO_OE_N_I)
         |-> {PORTC_OE_N_O[7:5], PORTC_OE_N_O[2:0]} == {GPIO_OE_N_I[7:5], GPIO_OE_N_I[2:0]};
   endproperty
   a_gpio: assert property (p_gpio) else $error("released pins not on gpio");
   property p_src;
      $past(POR_N_I) && $past(NVM_PORT_SEL_I | DEVICE_BLANK_I | LOGIC_PORT_CLAIM_TERM_I)
         |-> PORT_CLAIMED_O;
   endproperty
   a_src: assert property (p_src) else $error("pin claim missing");
   property p_tdo;
      !PORTC_OE_N_O[6] && PORT_CLAIMED_O && $past(PORT_CLAIMED_O)
         |-> SESSION_OPEN_O || $past(SESSION_OPEN_O);
   endproperty
   a_tdo: assert property (p_tdo) else $error("data out driven without session");
   property p_busy;
      SESSION_OPEN_O && $past(SESSION_OPEN_O) && !PORTC_OE_N_O[3] && $past(MEM_BUSY_I)
         && $past(MEM_BUSY_I, 2) |-> !PORTC_O[3];
   endproperty
   a_busy: assert property (p_busy) else $error("status high while busy");
   property p_secure;
      MEM_REQ_O && SECURITY_BIT_I && !unsec_reg |-> MEM_OP_O == 3'h3;
   endproperty
   a_secure: assert property (p_secure) else $error("command passed while secured");
   property p_unsec;
      SECURITY_CLEAR_O |-> MEM_REQ_O && MEM_OP_O == 3'h3;
   endproperty
   a_unsec: assert property (p_unsec) else $error("security clear without chip erase");
   property p_sector;
      MEM_REQ_O && MEM_OP_O == 3'h2 |-> MEM_SECTOR_O < 4'hc && !SECTOR_PROT_I[MEM_SECTOR_O];
   endproperty
   a_sector: assert property (p_sector) else $error("protected sector erased");
   // read data zero in reset or idle
   property p_rdata;
      !RST_N_I || !$past(REG_RD_I) |-> REG_RDATA_O == 8'h00;
   endproperty
   a_rdata: assert property (p_rdata) else $error("read data not cleared");
endmodule // jpe_port_checker

// >>> testbench/jpe_tap_ctrl.sv
// serial programming controller model on the test pins
`timescale 1ns/1ps
module jpe_tap_ctrl (
   input wire tdo_i,
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o
);
   int half_ns = 100;
   logic [23:0] cap = 24'h000000;
   logic tdo_seen = 1'b0;
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
   end
   ////////////////////////////////////////////////////////////////
   // mode and data set while clock low
   task automatic clk_bit(input logic m, input logic d);
      tms_o = m;
      tdi_o = d;
      #(half_ns) tck_o = 1'b1;
      // late sample: data out lags the filtered falling edge
      #(half_ns) tdo_seen = tdo_i;
      tck_o = 1'b0;
   endtask
   // five ones reach reset, then idle
   task automatic tap_reset();
      repeat (5) clk_bit(1'b1, 1'b0);
      clk_bit(1'b0, 1'b0);
      tdi_o = ~tdi_o;
   endtask
   // scan from idle, lsb first; clock then stands still
   task automatic scan(input logic ir, input int n, input logic [23:0] v);
      int i;
      #3;
      clk_bit(1'b1, 1'b0);
      if (ir) clk_bit(1'b1, 1'b0);
      clk_bit(1'b0, 1'b0);
      clk_bit(1'b0, 1'b0);
      for (i = 0; i < n; i++) begin
         clk_bit(i == n - 1, v[i]);
         cap[i] = tdo_seen;
      end
      clk_bit(1'b1, 1'b0);
      clk_bit(1'b0, 1'b0);
      tdi_o = ~tdi_o;
   endtask
endmodule // jpe_tap_ctrl

// >>> testbench/testbench.sv
// self-checking bench for the test-port claim block
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0, por_n = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, nvm = 1'b0;
   logic blank = 1'b0, term = 1'b0, secure = 1'b0, busy = 1'b0, ferr = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, gout = 8'h00, goe_n = 8'hff, mrd = 8'h5a;
   logic [11:0] prot = 12'h000;
   logic [31:0] lfsr = 32'h6e78;
   logic [26:0] exp_q[$];
   logic [26:0] e_mon;
   int num_errors = 0, tests_run = 0, cyc = 0, i;
   wire [7:0] rdata, pc_o, pc_oe_n, gin, mwd, ext, pins;
   wire [15:0] maddr;
   wire [3:0] msect;
   wire [2:0] mop;
   wire mreq, sclr, claimed, sopen, tck, tms, tdi;
   // pull-ups on idle pins; a driving pin wins
   assign ext = {2'b11, tdi, 3'b111, tck, tms};
   assign pins = (pc_o & ~pc_oe_n) | (ext & pc_oe_n);
   jpe_port i_dut (
      .CORE_CLK_I(clk), .POR_N_I(por_n), .RST_N_I(rst_n), .REG_ADDR_I(addr),
      .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
      .NVM_PORT_SEL_I(nvm), .DEVICE_BLANK_I(blank), .LOGIC_PORT_CLAIM_TERM_I(term),
      .SECURITY_BIT_I(secure), .SECTOR_PROT_I(prot), .PORTC_I(pins), .PORTC_O(pc_o),
      .PORTC_OE_N_O(pc_oe_n), .GPIO_OUT_I(gout), .GPIO_OE_N_I(goe_n), .GPIO_IN_O(gin),
      .MEM_BUSY_I(busy), .FLASH_ERR_I(ferr), .MEM_RDATA_I(mrd), .MEM_REQ_O(mreq),
      .MEM_OP_O(mop), .MEM_ADDR_O(maddr), .MEM_WDATA_O(mwd), .MEM_SECTOR_O(msect),
      .SECURITY_CLEAR_O(sclr), .PORT_CLAIMED_O(claimed), .SESSION_OPEN_O(sopen));
   jpe_tap_ctrl i_tap (.tdo_i(pins[6]), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
   initial begin
      forever #12.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic end_of_test();
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      chk(rdata, e);
   endtask
   task automatic dev_reset();
      @(negedge clk);
      rst_n = 1'b0;
      wait_n(4);
      rst_n = 1'b1;
      wait_n(10);
   endtask
   task automatic dr(input logic [23:0] v, input bit take, input logic [26:0] e);
      if (take) exp_q.push_back(e);
      i_tap.scan(1'b0, 24, v);
      wait_n(6);
   endtask
   task automatic ir(input logic [3:0] v);
      i_tap.scan(1'b1, 4, {20'h0, v});
      wait_n(6);
   endtask
   ////////////////////////////////////////////////////////////////
   // oldest expected request against each one seen; hang guard
   // mid-cycle look: the request pulse stands from one rising edge to the next
   always @(negedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         end_of_test();
      end
      if (mreq === 1'b1) begin
         e_mon = (exp_q.size() > 0) ? exp_q.pop_front() : 27'h7ffffff;
         if (e_mon[26:24] == 3'h1) chk({mop, mwd, maddr}, e_mon);
         else chk({mop, 20'h0, (mop == 3'h2) ? msect : 4'h0}, e_mon);
      end
   end
   initial begin
      wait_n(16);
      por_n = 1'b1;
      rst_n = 1'b1;
      wait_n(6);
      reg_wr(8'h10, 8'h01);
      reg_rd(8'h10, 8'h00);
      reg_rd(8'hc7, 8'h00);
      for (i = 0; i < 4; i++) begin
         lfsr = nxt(lfsr);
         gout = lfsr[7:0];
         goe_n = lfsr[15:8];
         {term, blank, nvm} = 3'b001 << i;
         if (i == 3) reg_wr(8'hc7, 8'h01);
         wait_n(4);
         chk({claimed, pc_oe_n[6:5], pc_oe_n[1:0]}, 5'h1f);
         if (i == 3) reg_rd(8'hc7, 8'h01);
         {term, blank, nvm} = 3'b000;
         if (i == 3) reg_wr(8'hc7, 8'h00);
         wait_n(4);
         chk({claimed, pc_oe_n}, {1'b0, goe_n});
         wait_n(2);
         chk(gin, (gout & ~goe_n) | (ext & goe_n));
      end
      reg_wr(8'hc7, 8'h01);
      dev_reset();
      reg_rd(8'hc7, 8'h00);
      reg_wr(8'hc7, 8'h01);
      wait_n(4);
      i_tap.tap_reset();
      ir(4'h1);
      chk(sopen, 1'b1);
      ir(4'h5);
      chk(i_tap.cap[3:0], 4'h1);
      for (i = 0; i < 3; i++) begin
         lfsr = nxt(lfsr);
         i_tap.half_ns = (i == 1) ? 300 : 100;
         dr(lfsr[23:0], 1'b1, {3'h1, lfsr[23:0]});
      end
      busy = 1'b1;
      wait_n(6);
      chk({pc_oe_n[3], pc_o[3]}, 2'b00);
      busy = 1'b0;
      wait_n(6);
      chk({pc_oe_n[3], pc_o[3]}, 2'b01);
      ferr = 1'b1;
      wait_n(1);
      ferr = 1'b0;
      wait_n(6);
      chk({pc_oe_n[4], pc_o[4]}, 2'b00);
      ir(4'h4);
      chk({pc_oe_n[4], pc_o[4]}, 2'b01);
      prot = 12'h004;
      ir(4'h6);
      dr(24'h000002, 1'b0, 27'h0);
      dr(24'h00000c, 1'b0, 27'h0);
      dr(24'h000003, 1'b1, {3'h2, 24'h000003});
      secure = 1'b1;
      ir(4'h5);
      dr(24'h123456, 1'b0, 27'h0);
      ir(4'h8);
      dr(24'h000010, 1'b0, 27'h0);
      chk(i_tap.cap[23:16], 8'h00);
      ir(4'h9);
      dr(24'h000010, 1'b0, 27'h0);
      exp_q.push_back({3'h3, 24'h0});
      ir(4'h7);
      chk(exp_q.size(), 0);
      ir(4'h5);
      dr(24'h654321, 1'b1, {3'h1, 24'h654321});
      ir(4'h8);
      dr(24'h000010, 1'b1, {3'h4, 24'h0});
      chk(i_tap.cap[23:16], mrd);
      dev_reset();
      chk(sopen, 1'b0);
      nvm = 1'b1;
      wait_n(4);
      i_tap.tap_reset();
      ir(4'h2);
      chk(pc_oe_n[3], 1'b1);
      busy = 1'b1;
      wait_n(6);
      chk({pc_oe_n[3], pc_o[3]}, 2'b00);
      busy = 1'b0;
      dev_reset();
      chk(sopen, 1'b1);
      chk(exp_q.size(), 0);
      end_of_test();
   end
endmodule // testbench
bind jpe_port jpe_port_checker i_chk (.*);
